// >>> timer8_defines.svh
`ifndef TIMER8_DEFINES_SVH
`define TIMER8_DEFINES_SVH

// Register byte addresses on the APB slave.
`define ADDR_CONTROL_A 12'h000
`define ADDR_CONTROL_B 12'h004
`define ADDR_COUNT 12'h008
`define ADDR_COMPARE_A 12'h00c
`define ADDR_COMPARE_B 12'h010
`define ADDR_IRQ_MASK 12'h014
`define ADDR_IRQ_FLAGS 12'h018
`define ADDR_IRQ_ACK 12'h01c

// Field positions in control register B.
`define CTLB_FORCE_A 7
`define CTLB_FORCE_B 6
`define CTLB_WAVE_HIGH 3

// Field positions in control register A.
`define CTLA_OUT_A_HI 7
`define CTLA_OUT_A_LO 6
`define CTLA_OUT_B_HI 5
`define CTLA_OUT_B_LO 4

// Flag and mask bit positions.
`define IRQ_MATCH_B 2
`define IRQ_MATCH_A 1
`define IRQ_OVERFLOW 0

// Counter landmarks and reset values.
`define COUNT_MAX 8'hff
`define COUNT_BOTTOM 8'h00
`define REG_RESET 8'h00

// Prescaler divide ratios minus one.
`define DIV8_LAST 10'h007
`define DIV64_LAST 10'h03f
`define DIV256_LAST 10'h0ff
`define DIV1024_LAST 10'h3ff

`endif

// >>> timer8_pkg.sv
package timer8_pkg;

  // Decoded waveform generation mode.
  typedef enum logic [2:0] {
    WAVE_NORMAL = 3'h0,
    WAVE_PC_FF = 3'h1,
    WAVE_CTC = 3'h2,
    WAVE_FAST_FF = 3'h3,
    WAVE_RSV4 = 3'h4,
    WAVE_PC_OCA = 3'h5,
    WAVE_RSV6 = 3'h6,
    WAVE_FAST_OCA = 3'h7
  } wave_mode_e;

  // Counter clock sources.
  typedef enum logic [2:0] {
    CLK_STOP = 3'h0,
    CLK_DIV1 = 3'h1,
    CLK_DIV8 = 3'h2,
    CLK_DIV64 = 3'h3,
    CLK_DIV256 = 3'h4,
    CLK_DIV1024 = 3'h5,
    CLK_EXT_FALL = 3'h6,
    CLK_EXT_RISE = 3'h7
  } clock_select_e;

  // Software visible control fields.
  typedef struct packed {
    logic [1:0] out_a_action;
    logic [1:0] out_b_action;
    logic wave_mode_high_bit;
    logic [1:0] wave_mode_low_bits;
    logic [2:0] clock_select_field;
  } control_s;

  // Per-channel waveform events.
  typedef struct packed {
    logic match;
    logic at_top;
    logic at_bottom;
    logic counting_down;
    logic forced;
  } wave_event_s;

endpackage

// >>> timer8_wave_channel.sv
`include "timer8_defines.svh"

// One waveform output stage, driven by match and period events.
module timer8_wave_channel (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [1:0] action_i,
  input wire logic [2:0] mode_i,
  input wire logic is_channel_a_i,
  input wire logic top_equal_i,
  input wire timer8_pkg::wave_event_s ev_i,
  output logic wave_o
);

  logic wave_q;
  logic wave_d;
  logic pwm;
  logic fast;

  // Next output level from the mode and the output action.
  always_comb begin
    pwm = mode_i[0];
    fast = mode_i[1];
    wave_d = wave_q;
    if (ev_i.forced && !pwm) begin
      case (action_i)
        2'b01: wave_d = ~wave_q;
        2'b10: wave_d = 1'b0;
        2'b11: wave_d = 1'b1;
        default: wave_d = wave_q;
      endcase
    end else if (!pwm) begin
      if (ev_i.match) begin
        case (action_i)
          2'b01: wave_d = ~wave_q;
          2'b10: wave_d = 1'b0;
          2'b11: wave_d = 1'b1;
          default: wave_d = wave_q;
        endcase
      end
    end else if (action_i == 2'b01) begin
      if (is_channel_a_i && mode_i[2] && ev_i.match) begin
        wave_d = ~wave_q;
      end
    end else if (action_i[1]) begin
      if (fast) begin
        if (ev_i.at_bottom) begin
          wave_d = ~action_i[0];
        end else if (ev_i.match && !top_equal_i) begin
          wave_d = action_i[0];
        end
      end else if (top_equal_i) begin
        if (ev_i.at_top) begin
          wave_d = action_i[0];
        end
      end else if (ev_i.match) begin
        wave_d = ev_i.counting_down ? ~action_i[0] : action_i[0];
      end
    end
  end

  // Output register.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wave_q <= 1'b0;
    end else if (ce_i) begin
      wave_q <= wave_d;
    end
  end

  assign wave_o = wave_q;

endmodule

// >>> timer8_dual_compare.sv
`include "timer8_defines.svh"

//////////////////////////////////////////////////////////////////////////////
module timer8_dual_compare (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic external_count_pin_i,
  input wire logic global_irq_enable_i,
  input wire logic [2:0] vector_ack_i,
  output logic wave_out_a_o,
  output logic wave_out_b_o,
  output logic [2:0] irq_o
);

  timer8_pkg::control_s ctl_q;
  logic [7:0] count_q;
  logic [7:0] cmp_a_buf_q;
  logic [7:0] cmp_b_buf_q;
  logic [7:0] cmp_a_q;
  logic [7:0] cmp_b_q;
  logic [2:0] mask_q;
  logic [2:0] flags_q;
  logic down_q;
  logic block_q;
  logic [9:0] presc_q;
  logic ext_s1_q;
  logic ext_s2_q;
  logic ext_prev_q;
  logic [31:0] prdata_q;
  logic wr_en;
  logic rd_en;
  logic tick;
  logic [7:0] top;
  logic pwm_mode;
  logic phase_mode;
  logic fast_mode;
  logic ovf_evt;
  logic match_a;
  logic match_b;
  logic at_top;
  logic at_bottom;
  logic count_wr;
  logic [7:0] count_d;
  logic down_d;
  logic force_a;
  logic force_b;
  timer8_pkg::wave_mode_e mode;
  timer8_pkg::wave_event_s ev_a;
  timer8_pkg::wave_event_s ev_b;

  // Returns true when the address names a mapped register.
  function automatic logic is_mapped(input logic [11:0] addr);
    is_mapped = (addr == `ADDR_CONTROL_A) || (addr == `ADDR_CONTROL_B) ||
                (addr == `ADDR_COUNT) || (addr == `ADDR_COMPARE_A) ||
                (addr == `ADDR_COMPARE_B) || (addr == `ADDR_IRQ_MASK) ||
                (addr == `ADDR_IRQ_FLAGS) || (addr == `ADDR_IRQ_ACK);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // APB slave.

  // Zero wait states; unmapped addresses answer with an error.
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !is_mapped(paddr_i);
  assign wr_en = ce_i && psel_i && penable_i && pwrite_i && is_mapped(paddr_i);
  assign rd_en = ce_i && psel_i && !penable_i && !pwrite_i;
  assign prdata_o = prdata_q;

  // Read data is registered in the setup cycle so it is stable in the access phase.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      prdata_q <= 32'h0000_0000;
    end else if (rd_en) begin
      case (paddr_i)
        `ADDR_CONTROL_A: prdata_q <= {24'h000000, ctl_q.out_a_action, ctl_q.out_b_action,
                                      2'b00, ctl_q.wave_mode_low_bits};
        `ADDR_CONTROL_B: prdata_q <= {24'h000000, 4'h0, ctl_q.wave_mode_high_bit,
                                      ctl_q.clock_select_field};
        `ADDR_COUNT: prdata_q <= {24'h000000, count_q};
        `ADDR_COMPARE_A: prdata_q <= {24'h000000, cmp_a_buf_q};
        `ADDR_COMPARE_B: prdata_q <= {24'h000000, cmp_b_buf_q};
        `ADDR_IRQ_MASK: prdata_q <= {29'h00000000, mask_q};
        `ADDR_IRQ_FLAGS: prdata_q <= {29'h00000000, flags_q};
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Control fields; force bits are strobes and are never stored.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctl_q <= '0;
    end else if (wr_en && paddr_i == `ADDR_CONTROL_A) begin
      ctl_q.out_a_action <= pwdata_i[`CTLA_OUT_A_HI:`CTLA_OUT_A_LO];
      ctl_q.out_b_action <= pwdata_i[`CTLA_OUT_B_HI:`CTLA_OUT_B_LO];
      ctl_q.wave_mode_low_bits <= pwdata_i[1:0];
    end else if (wr_en && paddr_i == `ADDR_CONTROL_B) begin
      ctl_q.wave_mode_high_bit <= pwdata_i[`CTLB_WAVE_HIGH];
      ctl_q.clock_select_field <= pwdata_i[2:0];
    end
  end

  // Interrupt enables.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mask_q <= 3'h0;
    end else if (wr_en && paddr_i == `ADDR_IRQ_MASK) begin
      mask_q <= pwdata_i[2:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Mode decode.

  // Mode from the high bit and the two low bits; 4 and 6 act as normal.
  always_comb begin
    mode = timer8_pkg::wave_mode_e'({ctl_q.wave_mode_high_bit,
                                     ctl_q.wave_mode_low_bits});
    phase_mode = (mode == timer8_pkg::WAVE_PC_FF) || (mode == timer8_pkg::WAVE_PC_OCA);
    fast_mode = (mode == timer8_pkg::WAVE_FAST_FF) || (mode == timer8_pkg::WAVE_FAST_OCA);
    pwm_mode = phase_mode || fast_mode;
    case (mode)
      timer8_pkg::WAVE_CTC: top = cmp_a_buf_q;
      timer8_pkg::WAVE_PC_OCA: top = cmp_a_q;
      timer8_pkg::WAVE_FAST_OCA: top = cmp_a_q;
      default: top = `COUNT_MAX;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Clock select and prescaler.

  // Free-running prescaler, restarted while the timer is stopped.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      presc_q <= 10'h000;
    end else if (ce_i) begin
      presc_q <= (ctl_q.clock_select_field == 3'h0) ? 10'h000 : presc_q + 10'h001;
    end
  end

  // Pin synchroniser and edge history; the pin is sampled whatever its direction.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else if (ce_i) begin
      ext_s1_q <= external_count_pin_i;
      ext_s2_q <= ext_s1_q;
      ext_prev_q <= ext_s2_q;
    end
  end

  // Timer tick from the selected source.
  always_comb begin
    case (timer8_pkg::clock_select_e'(ctl_q.clock_select_field))
      timer8_pkg::CLK_STOP: tick = 1'b0;
      timer8_pkg::CLK_DIV1: tick = 1'b1;
      timer8_pkg::CLK_DIV8: tick = presc_q[2:0] == 3'(`DIV8_LAST);
      timer8_pkg::CLK_DIV64: tick = presc_q[5:0] == 6'(`DIV64_LAST);
      timer8_pkg::CLK_DIV256: tick = presc_q[7:0] == 8'(`DIV256_LAST);
      timer8_pkg::CLK_DIV1024: tick = presc_q == `DIV1024_LAST;
      timer8_pkg::CLK_EXT_FALL: tick = ext_prev_q && !ext_s2_q;
      timer8_pkg::CLK_EXT_RISE: tick = !ext_prev_q && ext_s2_q;
      default: tick = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Counter and compare.

  assign count_wr = wr_en && paddr_i == `ADDR_COUNT;
  assign at_top = count_q == top;
  assign at_bottom = count_q == `COUNT_BOTTOM;
  assign match_a = tick && !block_q && count_q == cmp_a_q;
  assign match_b = tick && !block_q && count_q == cmp_b_q;

  // Next count and direction for each sequence.
  always_comb begin
    count_d = count_q + 8'h01;
    down_d = down_q;
    if (phase_mode) begin
      if (at_top) begin
        down_d = 1'b1;
      end else if (at_bottom) begin
        down_d = 1'b0;
      end
      count_d = (down_d && !at_bottom) ? count_q - 8'h01 : count_q + 8'h01;
      if (at_top && at_bottom) begin
        count_d = `COUNT_BOTTOM;
      end
    end else if (at_top) begin
      count_d = `COUNT_BOTTOM;
    end
  end

  // Counter register; a software write wins and blocks the next compare.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      count_q <= `REG_RESET;
      down_q <= 1'b0;
      block_q <= 1'b0;
    end else if (ce_i) begin
      if (count_wr) begin
        count_q <= pwdata_i[7:0];
        block_q <= 1'b1;
      end else if (tick) begin
        count_q <= count_d;
        down_q <= down_d;
        block_q <= 1'b0;
      end
    end
  end

  // Compare buffers and active compares, loaded per mode.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cmp_a_buf_q <= `REG_RESET;
      cmp_b_buf_q <= `REG_RESET;
      cmp_a_q <= `REG_RESET;
      cmp_b_q <= `REG_RESET;
    end else if (ce_i) begin
      if (wr_en && paddr_i == `ADDR_COMPARE_A) begin
        cmp_a_buf_q <= pwdata_i[7:0];
      end
      if (wr_en && paddr_i == `ADDR_COMPARE_B) begin
        cmp_b_buf_q <= pwdata_i[7:0];
      end
      if (!pwm_mode) begin
        cmp_a_q <= cmp_a_buf_q;
        cmp_b_q <= cmp_b_buf_q;
      end else if (tick && ((phase_mode && at_top) || (fast_mode && at_bottom))) begin
        cmp_a_q <= cmp_a_buf_q;
        cmp_b_q <= cmp_b_buf_q;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Flags and interrupt requests.

  // Overflow point by mode.
  always_comb begin
    case (mode)
      timer8_pkg::WAVE_PC_FF: ovf_evt = at_bottom;
      timer8_pkg::WAVE_PC_OCA: ovf_evt = at_bottom;
      timer8_pkg::WAVE_FAST_OCA: ovf_evt = at_top;
      default: ovf_evt = count_q == `COUNT_MAX;
    endcase
  end

  // Sticky flags; a new event wins over a clear in the same cycle.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      flags_q <= 3'h0;
    end else if (ce_i) begin
      for (int i = 0; i < 3; i++) begin
        if ((wr_en && (paddr_i == `ADDR_IRQ_FLAGS) && pwdata_i[i]) || vector_ack_i[i]) begin
          flags_q[i] <= 1'b0;
        end
      end
      if (match_b) begin
        flags_q[`IRQ_MATCH_B] <= 1'b1;
      end
      if (match_a) begin
        flags_q[`IRQ_MATCH_A] <= 1'b1;
      end
      if (tick && ovf_evt) begin
        flags_q[`IRQ_OVERFLOW] <= 1'b1;
      end
    end
  end

  // Requests need flag, enable and the global bit.
  assign irq_o = flags_q & mask_q & {3{global_irq_enable_i}};

  //////////////////////////////////////////////////////////////////////////////
  // Waveform channels.

  // Force strobes act only in non-PWM modes and touch neither flags nor counter.
  assign force_a = wr_en && paddr_i == `ADDR_CONTROL_B && pwdata_i[`CTLB_FORCE_A]
                   && !pwm_mode;
  assign force_b = wr_en && paddr_i == `ADDR_CONTROL_B && pwdata_i[`CTLB_FORCE_B]
                   && !pwm_mode;
  assign ev_a = '{match: match_a, at_top: tick && at_top, at_bottom: tick && at_bottom,
                  counting_down: down_q, forced: force_a};
  assign ev_b = '{match: match_b, at_top: tick && at_top, at_bottom: tick && at_bottom,
                  counting_down: down_q, forced: force_b};

  timer8_wave_channel u_wave_a (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .action_i(ctl_q.out_a_action),
    .mode_i(mode),
    .is_channel_a_i(1'b1),
    .top_equal_i(cmp_a_q == top),
    .ev_i(ev_a),
    .wave_o(wave_out_a_o)
  );

  timer8_wave_channel u_wave_b (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .action_i(ctl_q.out_b_action),
    .mode_i(mode),
    .is_channel_a_i(1'b0),
    .top_equal_i(cmp_b_q == top),
    .ev_i(ev_b),
    .wave_o(wave_out_b_o)
  );

endmodule

// >>> timer8_dual_compare_monitor.sv
`include "timer8_defines.svh"

// Port checker for the dual compare timer: read-back masks, interrupt gating, reset and map.
module timer8_dual_compare_monitor (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic external_count_pin_i,
  input wire logic global_irq_enable_i,
  input wire logic [2:0] vector_ack_i,
  input wire logic wave_out_a_o,
  input wire logic wave_out_b_o,
  input wire logic [2:0] irq_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  logic rd_acc;

  // A read in its access phase, when the read data must be valid.
  assign rd_acc = psel_i && penable_i && !pwrite_i;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions.
  ctlb_zero_a: assert property (
    rd_acc && paddr_i == `ADDR_CONTROL_B |-> prdata_o[7:4] == 4'h0)
    else $error("control B strobe or reserved bits read nonzero");
  irq_rsv_zero_a: assert property (
    rd_acc && (paddr_i == `ADDR_IRQ_MASK || paddr_i == `ADDR_IRQ_FLAGS)
    |-> prdata_o[7:3] == 5'h00)
    else $error("mask or flag reserved bits read nonzero");
  byte_wide_a: assert property (
    rd_acc |-> prdata_o[31:8] == 24'h000000)
    else $error("read data above the low byte nonzero");
  irq_gate_a: assert property (
    irq_o != 3'h0 |-> global_irq_enable_i)
    else $error("interrupt request without the global enable");
  freeze_a: assert property (
    !ce_i |=> $stable(wave_out_a_o) && $stable(wave_out_b_o))
    else $error("waveform output moved while the clock enable was low");
  map_err_a: assert property (
    psel_i && penable_i && paddr_i > `ADDR_IRQ_ACK |-> pslverr_o)
    else $error("unmapped access gave no slave error");
  map_ok_a: assert property (
    psel_i && penable_i && paddr_i <= `ADDR_IRQ_FLAGS && paddr_i[1:0] == 2'h0
    |-> pready_o && !pslverr_o)
    else $error("mapped access refused or stalled");
  reset_out_a: assert property (
    $rose(rst_n_i) |-> irq_o == 3'h0 && !wave_out_a_o && !wave_out_b_o)
    else $error("outputs not cleared by reset");
endmodule

bind timer8_dual_compare timer8_dual_compare_monitor mon (
  .clk_i(clk_i),
  .rst_n_i(rst_n_i),
  .ce_i(ce_i),
  .psel_i(psel_i),
  .penable_i(penable_i),
  .pwrite_i(pwrite_i),
  .paddr_i(paddr_i),
  .pwdata_i(pwdata_i),
  .prdata_o(prdata_o),
  .pready_o(pready_o),
  .pslverr_o(pslverr_o),
  .external_count_pin_i(external_count_pin_i),
  .global_irq_enable_i(global_irq_enable_i),
  .vector_ack_i(vector_ack_i),
  .wave_out_a_o(wave_out_a_o),
  .wave_out_b_o(wave_out_b_o),
  .irq_o(irq_o)
);

// >>> timer8_cpu_model.sv
// Stand-in for the CPU that takes timer interrupts after a chosen latency.
module timer8_cpu_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic serve_i,
  input wire logic [3:0] delay_i,
  input wire logic [2:0] irq_i,
  output logic [2:0] vector_ack_o
);
  logic [3:0] wait_q;

  // Only a raised request is served, one vector per pulse, overflow first.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !serve_i || irq_i == 3'h0 || vector_ack_o != 3'h0) begin
      wait_q <= 4'h0;
      vector_ack_o <= 3'h0;
    end else if (wait_q < delay_i) begin
      wait_q <= wait_q + 4'h1;
    end else begin
      vector_ack_o <= irq_i & (~irq_i + 3'h1);
    end
  end
endmodule

// >>> timer8_dual_compare_bench.sv
`include "timer8_defines.svh"

`define CHK(nm, e, g) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) begin \
      errors++; \
      $display("Error %s expected %h seen %h", nm, e, g); \
    end \
  end

// Register-level bench for the dual compare timer.
module timer8_dual_compare_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ce_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h00000000;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic external_count_pin_i = 1'b0;
  logic global_irq_enable_i = 1'b0;
  logic serve_i = 1'b0;
  logic [3:0] delay_i = 4'h5;
  logic [2:0] vector_ack_i;
  logic wave_out_a_o;
  logic wave_out_b_o;
  logic [2:0] irq_o;
  logic [7:0] rd;
  logic err;
  int errors = 0;
  int cmp_count = 0;

  always #2 clk_i = ~clk_i;

  timer8_dual_compare uut (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .external_count_pin_i(external_count_pin_i),
    .global_irq_enable_i(global_irq_enable_i),
    .vector_ack_i(vector_ack_i),
    .wave_out_a_o(wave_out_a_o),
    .wave_out_b_o(wave_out_b_o),
    .irq_o(irq_o)
  );

  timer8_cpu_model cpu (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .serve_i(serve_i),
    .delay_i(delay_i),
    .irq_i(irq_o),
    .vector_ack_o(vector_ack_i)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Closing report, reached from the end of the run or from a spent wait.
  task automatic close_out();
    $display("Comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // One APB transfer held until pready is sampled high, then one idle edge.
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= {24'h000000, d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1 && n < 16) begin
      n++;
      @(posedge clk_i);
    end
    if (n == 16) begin
      errors++;
      close_out();
    end
    rd = prdata_o[7:0];
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rchk(input string nm, input logic [11:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    `CHK(nm, e, rd)
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence; the counter is only rewritten while stopped.
  initial begin
    int n;
    logic w;
    logic v;
    logic [7:0] c;
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    for (int a = 0; a < 8; a++) rchk("reset value", 12'(4 * a), 8'h00);
    xfer(1'b0, 12'h020, 8'h00);
    `CHK("unmapped error", 1'b1, err)
    $display("Test reset done");
    wr(`ADDR_CONTROL_B, 8'hf8);
    rchk("control b", `ADDR_CONTROL_B, 8'h08);
    wr(`ADDR_CONTROL_B, 8'h00);
    wr(`ADDR_IRQ_MASK, 8'hff);
    rchk("mask", `ADDR_IRQ_MASK, 8'h07);
    wr(`ADDR_IRQ_MASK, 8'h00);
    wr(`ADDR_COMPARE_A, 8'h5a);
    rchk("compare a", `ADDR_COMPARE_A, 8'h5a);
    wr(`ADDR_IRQ_FLAGS, 8'hff);
    rchk("flags idle", `ADDR_IRQ_FLAGS, 8'h00);
    $display("Test registers done");
    wr(`ADDR_COMPARE_A, 8'hf8);
    wr(`ADDR_COMPARE_B, 8'h10);
    wr(`ADDR_COUNT, 8'hf0);
    wr(`ADDR_CONTROL_B, 8'h01);
    idle(40);
    wr(`ADDR_CONTROL_B, 8'h00);
    rchk("normal flags", `ADDR_IRQ_FLAGS, 8'h07);
    xfer(1'b0, `ADDR_COUNT, 8'h00);
    c = rd;
    idle(5);
    rchk("stopped count", `ADDR_COUNT, c);
    wr(`ADDR_IRQ_FLAGS, 8'h02);
    rchk("one flag cleared", `ADDR_IRQ_FLAGS, 8'h05);
    wr(`ADDR_IRQ_FLAGS, 8'h05);
    rchk("flags cleared", `ADDR_IRQ_FLAGS, 8'h00);
    $display("Test normal done");
    wr(`ADDR_COMPARE_B, 8'h80);
    wr(`ADDR_COUNT, 8'hfe);
    wr(`ADDR_CONTROL_B, 8'h01);
    idle(4);
    wr(`ADDR_CONTROL_B, 8'h00);
    rchk("overflow only", `ADDR_IRQ_FLAGS, 8'h01);
    wr(`ADDR_IRQ_MASK, 8'h01);
    `CHK("irq global off", 3'h0, irq_o)
    global_irq_enable_i <= 1'b1;
    @(posedge clk_i);
    `CHK("irq raised", 3'h1, irq_o)
    wr(`ADDR_IRQ_MASK, 8'h06);
    `CHK("irq masked", 3'h0, irq_o)
    wr(`ADDR_IRQ_MASK, 8'h01);
    serve_i <= 1'b1;
    n = 0;
    while (vector_ack_i === 3'h0 && n < 32) begin
      n++;
      @(posedge clk_i);
    end
    if (n == 32) begin
      errors++;
      close_out();
    end
    serve_i <= 1'b0;
    idle(2);
    rchk("vector clears", `ADDR_IRQ_FLAGS, 8'h00);
    `CHK("irq served", 3'h0, irq_o)
    $display("Test interrupt done");
    wr(`ADDR_COMPARE_A, 8'h0a);
    wr(`ADDR_COUNT, 8'h00);
    wr(`ADDR_CONTROL_A, 8'h02);
    wr(`ADDR_CONTROL_B, 8'h01);
    idle(60);
    wr(`ADDR_CONTROL_B, 8'h00);
    xfer(1'b0, `ADDR_COUNT, 8'h00);
    `CHK("clear on match top", 1'b1, rd <= 8'h0a)
    rchk("clear on match flags", `ADDR_IRQ_FLAGS, 8'h02);
    wr(`ADDR_COMPARE_A, 8'h20);
    for (int m = 0; m < 2; m++) begin
      wr(`ADDR_CONTROL_A, (m == 0) ? 8'h01 : 8'h03);
      wr(`ADDR_IRQ_FLAGS, 8'h07);
      wr(`ADDR_CONTROL_B, 8'h09);
      idle(100);
      wr(`ADDR_CONTROL_B, 8'h08);
      xfer(1'b0, `ADDR_COUNT, 8'h00);
      `CHK("pwm top", 1'b1, rd <= 8'h20)
      rchk("pwm flags", `ADDR_IRQ_FLAGS, 8'h03);
    end
    // Fixed TOP modes: fast sets overflow at MAX, phase correct only at BOTTOM.
    for (int m = 0; m < 2; m++) begin
      wr(`ADDR_CONTROL_B, 8'h00);
      wr(`ADDR_CONTROL_A, (m == 0) ? 8'h03 : 8'h01);
      wr(`ADDR_COUNT, (m == 0) ? 8'hf8 : 8'hff);
      wr(`ADDR_IRQ_FLAGS, 8'h07);
      wr(`ADDR_CONTROL_B, 8'h01);
      idle(20);
      wr(`ADDR_CONTROL_B, 8'h00);
      rchk("fixed top flags", `ADDR_IRQ_FLAGS, (m == 0) ? 8'h01 : 8'h00);
    end
    xfer(1'b0, `ADDR_COUNT, 8'h00);
    `CHK("phase down", 1'b1, rd >= 8'he6 && rd <= 8'hea)
    wr(`ADDR_IRQ_FLAGS, 8'h07);
    wr(`ADDR_CONTROL_A, 8'h43);
    w = wave_out_a_o;
    wr(`ADDR_CONTROL_B, 8'h88);
    idle(2);
    `CHK("force in pwm", w, wave_out_a_o)
    wr(`ADDR_CONTROL_B, 8'h00);
    wr(`ADDR_CONTROL_A, 8'h50);
    w = wave_out_a_o;
    v = wave_out_b_o;
    wr(`ADDR_CONTROL_B, 8'hc0);
    idle(2);
    `CHK("force toggles", ~w, wave_out_a_o)
    `CHK("force b toggles", ~v, wave_out_b_o)
    rchk("force no flag", `ADDR_IRQ_FLAGS, 8'h00);
    wr(`ADDR_COMPARE_B, 8'h33);
    wr(`ADDR_COUNT, 8'h33);
    wr(`ADDR_CONTROL_B, 8'h01);
    idle(6);
    wr(`ADDR_CONTROL_B, 8'h00);
    rchk("blocked match", `ADDR_IRQ_FLAGS, 8'h00);
    $display("Test modes done");
    for (int k = 6; k < 8; k++) begin
      wr(`ADDR_COUNT, 8'h00);
      wr(`ADDR_CONTROL_B, 8'(k));
      repeat (3) begin
        external_count_pin_i <= 1'b1;
        idle(4);
        external_count_pin_i <= 1'b0;
        idle(4);
      end
      wr(`ADDR_CONTROL_B, 8'h00);
      rchk("pin edges", `ADDR_COUNT, 8'h03);
    end
    wr(`ADDR_COUNT, 8'h00);
    wr(`ADDR_CONTROL_B, 8'h02);
    idle(80);
    wr(`ADDR_CONTROL_B, 8'h00);
    xfer(1'b0, `ADDR_COUNT, 8'h00);
    `CHK("divide by 8", 1'b1, rd >= 8'h09 && rd <= 8'h0b)
    c = rd;
    ce_i <= 1'b0;
    wr(`ADDR_COUNT, 8'h77);
    ce_i <= 1'b1;
    rchk("frozen write", `ADDR_COUNT, c);
    $display("Test clocks done");
    close_out();
  end
endmodule
